/* File: src/aaol_top.sv */
// Purpose: alarm post-processing between comparators and outputs
// Assumes: comparator flags and over-range synchronous to SYS_CLK
// Notes:   bit order of point vectors is lowest, low, high, highest from bit 0
module aaol_top #(
    parameter int unsigned TICK = aaol_pkg::TICK_CYCLES
) (
    input  wire logic                  SYS_CLK,
    input  wire logic                  RST,
    input  wire logic [3:0]            ADDR,
    input  wire logic [31:0]           WDATA,
    input  wire logic                  WR,
    input  wire logic                  RD,
    output logic      [31:0]           RDATA,
    input  wire aaol_pkg::aaol_cmp_type CMP,
    input  wire logic [13:0]           POWER_ON_DELAY_SETTING_SET,
    input  wire logic                  STANDBY_SET,
    input  wire logic                  EXT_RESET,
    output logic      [3:0]            ALARM_OUT,
    output logic      [4:0]            INDICATOR,
    output logic      [3:0]            PASS_SEL,
    output logic                       MEAS_HOLD
);

    aaol_pkg::aaol_state_type q;
    aaol_pkg::aaol_state_type d;

    logic [3:0] raw;
    logic [3:0] pm;
    logic [3:0] want;
    logic [3:0] newly;
    logic       pass;
    logic       blk;
    logic       run;
    logic       clr;
    logic       tick;

    // ----------------------------------------
    // alarm evaluation
    // ----------------------------------------
    // over-range drives the matching side
    assign raw[0] = CMP.lowest  | CMP.ovr_lo;
    assign raw[1] = CMP.l       | CMP.ovr_lo;
    assign raw[2] = CMP.h       | CMP.ovr_hi;
    assign raw[3] = CMP.highest | CMP.ovr_hi;
    assign blk  = (CMP.ovr_lo | CMP.ovr_hi) & ~q.trip;
    assign pass = ~raw[1] & ~raw[2];
    assign pm   = (q.route == aaol_pkg::ROUTE_NONE) ? 4'h0
                : 4'(4'h1 << (q.route - 3'h1));
    // routed bit carries pass, not own alarm
    assign want = (raw & ~pm) | (pm & {4{pass}});
    assign run  = (q.phase == aaol_pkg::PH_RUN);
    // latch off mode clears the latches and the freeze like the external reset
    assign clr  = q.xrst2 | (q.latch == aaol_pkg::LATCH_OFF);
    // pass bit never latches; frozen takes nothing new
    assign newly = want & ~pm
                 & {4{run & ~q.frozen & ~blk}}
                 & {4{q.latch != aaol_pkg::LATCH_OFF}};
    assign tick = (q.pre == 32'(TICK - 1));

    always_comb
    begin
        d       = q;
        d.rdata = 32'h0000_0000;
        // ----------------------------------------
        // register port
        // ----------------------------------------
        if (WR && ADDR == aaol_pkg::ADDR_CFG)
        begin
            d.route = aaol_pkg::aaol_route_type'(WDATA[aaol_pkg::CFG_ROUTE +: 3]);
            d.latch = aaol_pkg::aaol_latch_type'(WDATA[aaol_pkg::CFG_LATCH +: 2]);
            d.trip  = WDATA[aaol_pkg::CFG_TRIP];
            if (WDATA[aaol_pkg::CFG_ROUTE +: 3] > 3'h4)
            begin
                d.route = aaol_pkg::ROUTE_NONE;
            end
            if (WDATA[aaol_pkg::CFG_LATCH +: 2] == 2'h3)
            begin
                d.latch = aaol_pkg::LATCH_OFF;
            end
        end
        if (RD)
        begin
            case (ADDR)
                aaol_pkg::ADDR_CFG:
                    d.rdata = {26'h0, q.trip, q.latch, q.route};
                aaol_pkg::ADDR_STAT:
                    d.rdata = {14'h0, q.phase, q.frozen,
                               q.held, q.ind, q.out};
                default:
                    d.rdata = 32'h0000_0000;
            endcase
        end
        // ----------------------------------------
        // reset synchroniser and prescaler
        // ----------------------------------------
        // two-flop sampling of the external reset
        d.xrst1 = EXT_RESET;
        d.xrst2 = q.xrst1;
        d.pre   = tick ? 32'h0000_0000 : q.pre + 32'h0000_0001;
        // ----------------------------------------
        // startup sequence
        // ----------------------------------------
        case (q.phase)
            aaol_pkg::PH_INIT:
            begin
                d.dly   = (POWER_ON_DELAY_SETTING_SET > aaol_pkg::DLY_MAX)
                        ? aaol_pkg::DLY_MAX : POWER_ON_DELAY_SETTING_SET;
                d.stby  = STANDBY_SET;
                d.pre   = 32'h0000_0000;
                d.phase = aaol_pkg::PH_DELAY;
            end
            aaol_pkg::PH_DELAY:
            begin
                if (q.dly == 14'h0000)
                begin
                    d.phase = q.stby ? aaol_pkg::PH_STANDBY
                                     : aaol_pkg::PH_RUN;
                end
                else if (tick)
                begin
                    d.dly = q.dly - 14'h0001;
                end
            end
            aaol_pkg::PH_STANDBY:
            begin
                if (pass && !blk)
                begin
                    d.phase = aaol_pkg::PH_RUN;
                end
            end
            aaol_pkg::PH_RUN:
                d.phase = aaol_pkg::PH_RUN;
            default:
                d.phase = aaol_pkg::PH_INIT;
        endcase
        // ----------------------------------------
        // latching
        // ----------------------------------------
        // set wins over a simultaneous clear
        d.held = ((clr ? 4'h0 : q.held) & ~pm) | newly;
        // stop mode freezes on first latch
        d.frozen = ((clr || q.latch != aaol_pkg::LATCH_STOP)
                    ? 1'b0 : q.frozen)
                 | ((q.latch == aaol_pkg::LATCH_STOP) && (|newly));
        // ----------------------------------------
        // outputs
        // ----------------------------------------
        // no alarm output leaves before run phase; the indicator follows the points in every phase except while over-range blanks it
        if (!run)
        begin
            d.out = 4'h0;
        end
        else if (q.frozen && !clr)
        begin
            d.out = q.out;
        end
        else
        begin
            d.out = want | (q.held & ~pm);
        end
        d.ind = {pass, raw};
        if (blk)
        begin
            d.out = 4'h0;
            d.ind = 5'h00;
        end
        // downstream timing uses pass settings here
        d.psel = pm;
    end

    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            q       <= '0;
            q.phase <= aaol_pkg::PH_INIT;
            q.route <= aaol_pkg::ROUTE_NONE;
            q.latch <= aaol_pkg::LATCH_OFF;
            q.trip  <= 1'b1;
            q.dly   <= aaol_pkg::DLY_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    assign RDATA     = q.rdata;
    assign ALARM_OUT = q.out;
    assign INDICATOR = q.ind;
    assign PASS_SEL  = q.psel;
    assign MEAS_HOLD = q.frozen;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    a_startup_quiet: assert property (
        !run |=> ALARM_OUT == 4'h0)
        else $error("output during startup");
    a_pass_on: assert property (
        run && !q.frozen && !blk && (|pm) && pass
        |=> |(ALARM_OUT & $past(pm)))
        else $error("pass output missing");
    a_pass_own_off: assert property (
        run && !q.frozen && !blk && (|pm) && !pass
        |=> (ALARM_OUT & $past(pm)) == 4'h0)
        else $error("routed point drove own alarm");
    a_low_alarm: assert property (
        run && !q.frozen && !blk && !pm[1] && CMP.l
        |=> ALARM_OUT[1])
        else $error("low alarm missing");
    a_latch_keep: assert property (
        !clr && $stable(q.route) |=> (q.held & $past(q.held)) == $past(q.held))
        else $error("latch lost");
    a_latch_off_clr: assert property (
        q.latch == aaol_pkg::LATCH_OFF |=> q.held == 4'h0)
        else $error("latch not cleared");
    a_cont_tracks: assert property (
        q.latch != aaol_pkg::LATCH_STOP |=> !MEAS_HOLD)
        else $error("hold outside stop mode");
    a_stop_freeze: assert property (
        q.latch == aaol_pkg::LATCH_STOP && (|newly) |=> MEAS_HOLD)
        else $error("freeze missing");
    a_frozen_stable: assert property (
        q.frozen && !clr && !blk |=> ALARM_OUT == $past(ALARM_OUT))
        else $error("new output while frozen");
    a_ovr_blank: assert property (
        blk |=> ALARM_OUT == 4'h0 && INDICATOR == 5'h00)
        else $error("over-range not blanked");
    a_pass_unlatched: assert property (
        $stable(q.route) |-> (q.held & pm) == 4'h0)
        else $error("pass output latched");
    a_high_alarm: assert property (
        run && !q.frozen && !blk && !pm[2] && CMP.h
        |=> ALARM_OUT[2])
        else $error("high alarm missing");
    a_ovr_low_trip: assert property (
        run && !q.frozen && q.trip && CMP.ovr_lo && !pm[0]
        |=> ALARM_OUT[0])
        else $error("over-range low side missing");
    a_ind_follow: assert property (
        !blk |=> INDICATOR == {$past(pass), $past(raw)})
        else $error("indicator not following points");
    a_pass_sel: assert property (
        1'b1 |=> PASS_SEL == $past(pm))
        else $error("pass selection wrong");

    // ----------------------------------------
    // clearing and startup checks
    // ----------------------------------------
    // a clear cycle keeps only what is newly set in it
    a_ext_clear: assert property (
        q.xrst2 |=> q.held == $past(newly))
        else $error("external reset left a latch");
    a_delay_hold: assert property (
        q.phase == aaol_pkg::PH_DELAY && !tick |=> q.dly == $past(q.dly))
        else $error("delay moved between ticks");
    a_delay_wait: assert property (
        q.phase == aaol_pkg::PH_DELAY && q.dly != 14'h0000
        |=> q.phase == aaol_pkg::PH_DELAY)
        else $error("delay ended early");
    a_standby_wait: assert property (
        q.phase == aaol_pkg::PH_STANDBY && !pass
        |=> q.phase == aaol_pkg::PH_STANDBY)
        else $error("standby left outside pass zone");
    a_settings_once: assert property (
        q.phase != aaol_pkg::PH_INIT |=> $stable(q.stby))
        else $error("standby setting changed after power-up");

    c_delay_done: cover property (q.phase == aaol_pkg::PH_DELAY
                                  ##1 q.phase == aaol_pkg::PH_RUN);
    c_standby: cover property (q.phase == aaol_pkg::PH_STANDBY
                               ##1 q.phase == aaol_pkg::PH_RUN);
    c_freeze: cover property (!MEAS_HOLD ##1 MEAS_HOLD);
    c_ext_clear: cover property ((|q.held) && q.xrst2 ##1 q.held == 4'h0);
    c_pass_routed: cover property (run && (|pm) && pass ##1 |(ALARM_OUT & PASS_SEL));

endmodule : aaol_top

/* File: src/aaol_pkg.sv */
// Purpose: constants and types of the advanced alarm output logic
// Assumes: 40 MHz system clock, four setpoint comparators upstream
// Notes:   register offsets are byte addresses on the plain port
package aaol_pkg;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int unsigned CLK_HZ      = 40_000_000;
    localparam int unsigned TICK_MS     = 100;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam logic [13:0] DLY_MAX     = 14'h270F;
    localparam logic [13:0] DLY_RESET   = 14'h0000;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [3:0]  ADDR_CFG    = 4'h0;
    localparam logic [3:0]  ADDR_STAT   = 4'h4;
    localparam int unsigned CFG_ROUTE   = 0;
    localparam int unsigned CFG_LATCH   = 3;
    localparam int unsigned CFG_TRIP    = 5;

    typedef enum logic [2:0] {
        ROUTE_NONE    = 3'h0,
        ROUTE_LOWEST  = 3'h1,
        ROUTE_L       = 3'h2,
        ROUTE_H       = 3'h3,
        ROUTE_HIGHEST = 3'h4
    } aaol_route_type;

    typedef enum logic [1:0] {
        LATCH_OFF  = 2'h0,
        LATCH_CONT = 2'h1,
        LATCH_STOP = 2'h2
    } aaol_latch_type;

    typedef enum logic [3:0] {
        PH_INIT    = 4'h1,
        PH_DELAY   = 4'h2,
        PH_STANDBY = 4'h4,
        PH_RUN     = 4'h8
    } aaol_phase_type;

    // comparator flags: lowest below lowest setpoint, l below low,
    // h above high, highest above highest setpoint
    typedef struct packed {
        logic ovr_lo;
        logic ovr_hi;
        logic highest;
        logic h;
        logic l;
        logic lowest;
    } aaol_cmp_type;

    typedef struct packed {
        aaol_phase_type phase;
        aaol_route_type route;
        aaol_latch_type latch;
        logic           trip;
        logic           stby;
        logic [13:0]    dly;
        logic [31:0]    pre;
        logic           xrst1;
        logic           xrst2;
        logic [3:0]     held;
        logic           frozen;
        logic [3:0]     out;
        logic [4:0]     ind;
        logic [3:0]     psel;
        logic [31:0]    rdata;
    } aaol_state_type;

endpackage : aaol_pkg

/* File: testbench/aaol_relay_model.sv */
// Purpose: far side of the alarm block: relay bank and reset button
// Assumes: relays follow the block's sampling clock
// Notes:   the button press is one clock long, the shortest legal press
module aaol_relay_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       clr_req,
    input  wire logic [3:0] alarm_out,
    output logic            ext_reset,
    output logic [3:0]      relay_q
);
    timeunit 1ns;
    timeprecision 100ps;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ext_reset <= 1'b0;
            relay_q   <= 4'h0;
        end
        else
        begin
            ext_reset <= clr_req;
            relay_q   <= alarm_out;
        end
    end
endmodule : aaol_relay_model

/* File: testbench/aaol_top_tb.sv */
// Purpose: self-checking bench of the alarm output logic
// Assumes: TICK shortened to 4 cycles per 0.1 s step
// Notes:   expectations come from exp_alarm or fixed values, never from the design
module aaol_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned TICK = 4;
    logic                   sys_clk = 1'b0;
    logic                   rst = 1'b1;
    logic [3:0]             addr = 4'h0;
    logic [31:0]            wdata = 32'h0;
    logic                   wr = 1'b0;
    logic                   rd = 1'b0;
    logic [31:0]            rdata;
    aaol_pkg::aaol_cmp_type cmp = '0;
    aaol_pkg::aaol_cmp_type c;
    logic [13:0]            dly_set = 14'h0002;
    logic                   stby_set = 1'b0;
    logic                   clr_req = 1'b0;
    logic                   ext_reset;
    logic [3:0]             alarm_out;
    logic [4:0]             indicator;
    logic [3:0]             pass_sel;
    logic                   meas_hold;
    logic [3:0]             relay;
    logic [31:0]            d;
    logic [2:0]             rt;
    logic                   tr;
    int                     n;
    int                     err_total = 0;
    int                     comparisons = 0;

    always #12.5 sys_clk = ~sys_clk;

    aaol_top #(.TICK(TICK)) uut (
        .SYS_CLK(sys_clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .CMP(cmp), .POWER_ON_DELAY_SETTING_SET(dly_set), .STANDBY_SET(stby_set),
        .EXT_RESET(ext_reset), .ALARM_OUT(alarm_out), .INDICATOR(indicator),
        .PASS_SEL(pass_sel), .MEAS_HOLD(meas_hold));
    aaol_relay_model model (.clk(sys_clk), .rst(rst), .clr_req(clr_req),
        .alarm_out(alarm_out), .ext_reset(ext_reset), .relay_q(relay));

    // ----------------------------------------
    // checking and bus tasks
    // ----------------------------------------
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr_reg(logic [3:0] a, logic [31:0] v);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge sys_clk);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(logic [3:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge sys_clk);
        rd   <= 1'b0;
        #1;
        v = rdata;
    endtask : rd_reg

    task automatic step(aaol_pkg::aaol_cmp_type v, int cycles);
        @(posedge sys_clk);
        cmp <= v;
        repeat (cycles) @(posedge sys_clk);
        #1;
    endtask : step

    task automatic do_reset(logic [13:0] dly, logic stby);
        @(posedge sys_clk);
        rst      <= 1'b1;
        dly_set  <= dly;
        stby_set <= stby;
        repeat (12) @(posedge sys_clk);
        rst      <= 1'b0;
    endtask : do_reset

    // in band means neither low nor high side is tripped
    function automatic logic [12:0] exp_alarm(aaol_pkg::aaol_cmp_type v, logic [2:0] r,
                                              logic t);
        logic [3:0] raw;
        logic [3:0] out;
        logic [3:0] sel;
        logic       pass;
        raw  = {v.highest | (t & v.ovr_hi), v.h | (t & v.ovr_hi),
                v.l | (t & v.ovr_lo), v.lowest | (t & v.ovr_lo)};
        pass = ~raw[1] & ~raw[2];
        out  = raw;
        sel  = 4'h0;
        if (r != 3'h0)
        begin
            out[r - 3'h1] = pass;
            sel[r - 3'h1] = 1'b1;
        end
        if (!t && (v.ovr_hi || v.ovr_lo))
            return {sel, 9'h000};
        return {sel, pass, raw, out};
    endfunction : exp_alarm

    task automatic check_alarm(aaol_pkg::aaol_cmp_type v, logic [2:0] r, logic t);
        logic [12:0] e;
        e = exp_alarm(v, r, t);
        step(v, 3);
        check("alarm_out", alarm_out, e[3:0]);
        check("indicator", indicator, e[8:4]);
        check("pass_sel", pass_sel, e[12:9]);
    endtask : check_alarm

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        void'($urandom(32'hA486EA05));
        do_reset(14'h0002, 1'b0);
        step(6'h02, 3);
        check("alarm_out", alarm_out, 4'h0);
        for (n = 0; n < 100 && alarm_out !== 4'h2; n++)
            @(posedge sys_clk) #1;
        if (n == 100)
        begin
            err_total++;
            complete_run();
        end
        check("delay_elapsed", 32'(n >= 2 * TICK - 3 && n <= 2 * TICK), 32'h1);
        // phase run, low point on in output and indicator
        rd_reg(aaol_pkg::ADDR_STAT, d);
        check("stat_run", d, 32'h0002_0022);
        @(posedge sys_clk);
        dly_set  <= 14'h3FFF;
        stby_set <= 1'b1;
        step(6'h02, 3);
        check("late_setting", alarm_out, 4'h2);
        rd_reg(aaol_pkg::ADDR_CFG, d);
        check("cfg_reset", d, 32'h20);
        rd_reg(4'h8, d);
        check("unmapped", d, 32'h0);
        // route code above four and latch code 3 are refused
        wr_reg(aaol_pkg::ADDR_CFG, 32'h3F);
        rd_reg(aaol_pkg::ADDR_CFG, d);
        check("latch_code3", d, 32'h20);
        for (int r = 1; r <= 4; r++)
        begin
            wr_reg(aaol_pkg::ADDR_CFG, 32'h20 | r);
            check_alarm(6'h00, 3'(r), 1'b1);
            check_alarm(6'h04, 3'(r), 1'b1);
        end
        for (int i = 0; i < 40; i++)
        begin
            c  = 6'($urandom());
            if (c.ovr_hi)
                c.ovr_lo = 1'b0;
            rt = 3'($urandom_range(0, 4));
            tr = 1'($urandom_range(0, 1));
            wr_reg(aaol_pkg::ADDR_CFG, {26'h0, tr, 2'h0, rt});
            check_alarm(c, rt, tr);
        end
        // stop mode: first latch freezes, nothing new while frozen
        // in band first, so no random leftover latches on the mode change
        step(6'h00, 2);
        wr_reg(aaol_pkg::ADDR_CFG, 32'h30);
        step(6'h02, 3);
        step(6'h00, 3);
        check("stop_held", alarm_out, 4'h2);
        check("frozen", meas_hold, 1'b1);
        step(6'h04, 3);
        check("no_new", alarm_out, 4'h2);
        @(posedge sys_clk);
        clr_req <= 1'b1;
        cmp     <= 6'h00;
        @(posedge sys_clk);
        clr_req <= 1'b0;
        repeat (6) @(posedge sys_clk);
        #1;
        check("ext_clear", alarm_out, 4'h0);
        check("unfrozen", meas_hold, 1'b0);
        wr_reg(aaol_pkg::ADDR_CFG, 32'h29);
        step(6'h02, 3);
        step(6'h00, 3);
        check("cont_held", alarm_out, 4'h1 | 4'h2);
        check("tracking", meas_hold, 1'b0);
        check("relay", relay, 4'h3);
        step(6'h02, 3);
        check("pass_unlatched", alarm_out, 4'h2);
        do_reset(14'h0000, 1'b1);
        step(6'h02, 10);
        check("powerup_clear", alarm_out, 4'h0);
        step(6'h00, 3);
        check_alarm(6'h02, 3'h0, 1'b1);
        complete_run();
    end
endmodule : aaol_top_tb
